/* File: rtl/dmc_mode_regs.sv */
/*
  Mode-control register bank of the converter: filter control (two low
  fields), mode and reset, zero flag enable, zero status and identifier.
  Reached through the control port as parallel 16-bit command words; the
  serial shifter in front of it presents one word per cmd_valid pulse.
  No command is refused or stalled; a written field shows on the edge
  after the command, a read answer one cycle after it.
*/
// Function
// - Roll-off bit: 0 sharp, 1 slow
// - Zero-hold holds bipolar zero on both-channel zero
// - Zero-hold inactive in one-bit stream mode
// - Command bit 15: 0 write, 1 read
// - Soft reset write-only, 1 gives one pulse
// - Stream mode bit enables one-bit stream input
// - Bypass bit: 1 uses external digital filter
// - Monaural bit: both channels balanced, one input
// - Channel pick: 0 left, 1 right, monaural_select only
// - Rate: 00 x64, 01 x32, 10 x128, 11 reserved
// - Stream mode: rate selects stream bit clock
// - Stream zero pattern: 00 off, 01 even, 1x 96h
// - PCM zero enable gates flags, resets to 1
// - Status bit1 right, bit0 left, match pins
// - Status and identifier read-only, read bit 1
// - Identifier: five bits in bits 4:0
`timescale 1ns/1ps
`default_nettype none

// Field positions, indices and reset values
`include "dmc_regs.svh"

module dmc_mode_regs
  import dmc_pkg::*;
#(
  parameter logic [`DMC_ID_W-1:0] DEVICE_ID = 5'h00 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  // Control port, one command word per pulse
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  output logic rsp_valid,
  output logic [15:0] rsp_word,
  // Raw zero detections from the datapath
  input wire dmc_pkg::dmc_pair_s pcm_zero,
  input wire dmc_pkg::dmc_pair_s even_zero,
  input wire dmc_pkg::dmc_pair_s pat96_zero,
  // Settings and status towards the datapath and pins
  output dmc_pkg::dmc_mode_s mode,
  output logic [1:0] oversample_select,
  output logic [1:0] stream_bitclk_select,
  output logic monaural_select_right_pick,
  output logic hold_bipolar_zero,
  output logic soft_reset_pulse,
  output logic zero_pin_left,
  output logic zero_pin_right,
  output logic [`DMC_ID_W-1:0] device_identifier_field
);

  // Command decode
  dmc_cmd_s cmd;
  logic wr_en;
  logic rd_en;
  logic sreset_req;
  logic wr_filt;
  logic wr_mode;
  logic wr_zen;

  // Stored fields, one flop per bit
  logic rolloff_select_q;
  logic zero_hold_mute_enable_q;
  logic one_bit_stream_mode_q;
  logic filter_bypass_q;
  logic monaural_select_q;
  logic monaural_select_channel_pick_q;
  logic [1:0] modulator_rate_select_q;
  logic [1:0] stream_zero_pattern_q;
  logic pcm_zero_flag_enable_q;
  logic soft_reset_q;

  // Read answer path
  logic rsp_valid_q;
  logic [15:0] rsp_word_q;
  logic [7:0] rd_data;
  logic rd_fixed_dir;

  // Zero-hold and flag outputs
  logic hold_q;
  dmc_pair_s flags;

  //////////////////////////////////////////////////////////////////////////
  // Command word split
  assign cmd = cmd_word;
  assign wr_en = cmd_valid & (cmd.rw == `DMC_CMD_WRITE);
  assign rd_en = cmd_valid & (cmd.rw == `DMC_CMD_READ);

  // Per-register write strobes; writes to the read-only and unmapped
  // indices match none of them and so change nothing
  assign wr_filt = wr_en & (cmd.index == `DMC_IDX_FILTER_CTRL);
  assign wr_mode = wr_en & (cmd.index == `DMC_IDX_MODE_RESET);
  assign wr_zen = wr_en & (cmd.index == `DMC_IDX_ZERO_EN);

  // A soft reset request is a write of 1 to the write-only reset field
  assign sreset_req = wr_mode & cmd.data[`DMC_MODE_SOFTRST_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Soft reset: exactly one pulse per request; the pulse cycle also
  // returns every setting to its reset value. A write that lands in the
  // pulse cycle is lost to the reset, so a host leaves one idle cycle
  // after a reset request. Zero flags and the hold follow the live
  // detectors and need no clearing.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= sreset_req;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Filter control fields
  // Both are plain read/write bits; the rest of the byte is not kept
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rolloff_select_q <= `DMC_RST_ROLLOFF;
      zero_hold_mute_enable_q <= `DMC_RST_ZHOLD;
    end else if (soft_reset_q) begin
      rolloff_select_q <= `DMC_RST_ROLLOFF;
      zero_hold_mute_enable_q <= `DMC_RST_ZHOLD;
    end else if (wr_filt) begin
      rolloff_select_q <= cmd.data[`DMC_FCTL_ROLLOFF_BIT];
      zero_hold_mute_enable_q <= cmd.data[`DMC_FCTL_ZHOLD_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode fields; the reset field itself is not stored
  // Stream and bypass are kept apart; the datapath settles a clash
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      one_bit_stream_mode_q <= `DMC_RST_STREAM;
      filter_bypass_q <= `DMC_RST_BYPASS;
      monaural_select_q <= `DMC_RST_MONAURAL_SELECT;
      monaural_select_channel_pick_q <= `DMC_RST_PICK;
      modulator_rate_select_q <= `DMC_RST_RATE;
    end else if (soft_reset_q) begin
      one_bit_stream_mode_q <= `DMC_RST_STREAM;
      filter_bypass_q <= `DMC_RST_BYPASS;
      monaural_select_q <= `DMC_RST_MONAURAL_SELECT;
      monaural_select_channel_pick_q <= `DMC_RST_PICK;
      modulator_rate_select_q <= `DMC_RST_RATE;
    end else if (wr_mode) begin
      // Same word carrying a reset request still lands; the pulse then
      // clears it one cycle later
      one_bit_stream_mode_q <= cmd.data[`DMC_MODE_STREAM_BIT];
      filter_bypass_q <= cmd.data[`DMC_MODE_BYPASS_BIT];
      monaural_select_q <= cmd.data[`DMC_MODE_MONAURAL_SELECT_BIT];
      monaural_select_channel_pick_q <= cmd.data[`DMC_MODE_PICK_BIT];
      modulator_rate_select_q <=
        cmd.data[`DMC_MODE_RATE_MSB:`DMC_MODE_RATE_LSB];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Zero flag enable fields
  // The PCM enable starts at 1 so the pins work without any setup
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stream_zero_pattern_q <= `DMC_RST_PAT;
      pcm_zero_flag_enable_q <= `DMC_RST_PCMEN;
    end else if (soft_reset_q) begin
      stream_zero_pattern_q <= `DMC_RST_PAT;
      pcm_zero_flag_enable_q <= `DMC_RST_PCMEN;
    end else if (wr_zen) begin
      stream_zero_pattern_q <=
        cmd.data[`DMC_ZEN_PAT_MSB:`DMC_ZEN_PAT_LSB];
      pcm_zero_flag_enable_q <= cmd.data[`DMC_ZEN_PCMEN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Zero flags; the status register and both pins read the same flops
  // The unit registers the flags, so pins lag the detectors by a cycle
  dmc_zero_flags u_zero (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .stream_mode(one_bit_stream_mode_q),
    .pcm_enable(pcm_zero_flag_enable_q),
    .pattern_sel(stream_zero_pattern_q),
    .pcm_zero(pcm_zero),
    .even_zero(even_zero),
    .pat96_zero(pat96_zero),
    .flags(flags)
  );

  assign zero_pin_left = flags.left;
  assign zero_pin_right = flags.right;

  //////////////////////////////////////////////////////////////////////////
  // Zero-hold: only on a simultaneous zero of both PCM channels, and never
  // in stream mode where the PCM detector means nothing
  // The flag enable does not gate it: muting follows the detectors
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= zero_hold_mute_enable_q & ~one_bit_stream_mode_q &
                pcm_zero.left & pcm_zero.right;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data mux; unmapped indices read as zero
  // Status reads see the flag flops as they stand at the taken edge
  always_comb begin
    rd_data = 8'h00;
    rd_fixed_dir = 1'b0;
    case (cmd.index)
      `DMC_IDX_FILTER_CTRL: begin
        rd_data[`DMC_FCTL_ROLLOFF_BIT] = rolloff_select_q;
        rd_data[`DMC_FCTL_ZHOLD_BIT] = zero_hold_mute_enable_q;
      end
      `DMC_IDX_MODE_RESET: begin
        // Reset field is write-only and reads 0
        rd_data[`DMC_MODE_STREAM_BIT] = one_bit_stream_mode_q;
        rd_data[`DMC_MODE_BYPASS_BIT] = filter_bypass_q;
        rd_data[`DMC_MODE_MONAURAL_SELECT_BIT] = monaural_select_q;
        rd_data[`DMC_MODE_PICK_BIT] = monaural_select_channel_pick_q;
        rd_data[`DMC_MODE_RATE_MSB:`DMC_MODE_RATE_LSB] =
          modulator_rate_select_q;
      end
      `DMC_IDX_ZERO_EN: begin
        rd_data[`DMC_ZEN_PAT_MSB:`DMC_ZEN_PAT_LSB] = stream_zero_pattern_q;
        rd_data[`DMC_ZEN_PCMEN_BIT] = pcm_zero_flag_enable_q;
      end
      `DMC_IDX_ZERO_STAT: begin
        rd_fixed_dir = 1'b1;
        rd_data[`DMC_ZST_RIGHT_BIT] = flags.right;
        rd_data[`DMC_ZST_LEFT_BIT] = flags.left;
      end
      `DMC_IDX_DEV_ID: begin
        rd_fixed_dir = 1'b1;
        rd_data[`DMC_ID_W-1:0] = DEVICE_ID;
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Read answer, one cycle after the command; writes to the two
  // read-only registers are dropped by the decode above
  // Writes give no answer; rsp_word keeps the last read until the next
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_word_q <= 16'h0000;
    end else begin
      rsp_valid_q <= rd_en;
      if (rd_en) begin
        // Read-only registers always show 1; others echo the read bit
        rsp_word_q <= {cmd.rw | rd_fixed_dir, cmd.index, rd_data};
      end
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_word = rsp_word_q;

  //////////////////////////////////////////////////////////////////////////
  // Settings towards the datapath, gathered in one process so the mode
  // word has a single driver
  always_comb begin
    mode.rolloff = rolloff_select_q;
    mode.zero_hold = zero_hold_mute_enable_q;
    mode.stream = one_bit_stream_mode_q;
    mode.bypass = filter_bypass_q;
    mode.monaural_select = monaural_select_q;
    mode.pick = monaural_select_channel_pick_q;
    mode.rate = modulator_rate_select_q;
  end

  // The rate field serves the modulator in PCM modes and the stream bit
  // clock in stream mode; the unused path sees the default code so it
  // never follows a setting meant for the other
  // Reserved code 11 is passed on as stored
  assign oversample_select = one_bit_stream_mode_q ? `DMC_RATE_X64 :
                             modulator_rate_select_q;
  assign stream_bitclk_select = one_bit_stream_mode_q ?
                                modulator_rate_select_q :
                                `DMC_RATE_X64;

  // Channel pick matters only in monaural mode,
  // so a stereo datapath never acts on a stale pick
  assign monaural_select_right_pick = monaural_select_q & monaural_select_channel_pick_q;
  assign hold_bipolar_zero = hold_q;
  assign soft_reset_pulse = soft_reset_q;
  // Fixed identifier, also shown on a port for the address match
  assign device_identifier_field = DEVICE_ID;

endmodule

`default_nettype wire

/* File: pkg/dmc_regs.svh */
/*
  Register indices, field positions, reset values and fixed codes of the
  mode-control register bank. Included by the package and by the design
  files; the including file supplies no definitions of its own.
*/
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH

// Register indices, carried in the index field of a command word
`define DMC_IDX_FILTER_CTRL 7'h13
`define DMC_IDX_MODE_RESET 7'h14
`define DMC_IDX_ZERO_EN 7'h15
`define DMC_IDX_ZERO_STAT 7'h16
`define DMC_IDX_DEV_ID 7'h17

// Command word layout
`define DMC_CMD_RW_BIT 15
`define DMC_CMD_IDX_MSB 14
`define DMC_CMD_IDX_LSB 8
`define DMC_CMD_DATA_MSB 7
`define DMC_CMD_DATA_LSB 0
`define DMC_CMD_WRITE 1'b0
`define DMC_CMD_READ 1'b1

// Filter control register fields
`define DMC_FCTL_ROLLOFF_BIT 1
`define DMC_FCTL_ZHOLD_BIT 0

// Mode and reset register fields
`define DMC_MODE_SOFTRST_BIT 6
`define DMC_MODE_STREAM_BIT 5
`define DMC_MODE_BYPASS_BIT 4
`define DMC_MODE_MONAURAL_SELECT_BIT 3
`define DMC_MODE_PICK_BIT 2
`define DMC_MODE_RATE_MSB 1
`define DMC_MODE_RATE_LSB 0

// Zero flag enable register fields
`define DMC_ZEN_PAT_MSB 2
`define DMC_ZEN_PAT_LSB 1
`define DMC_ZEN_PCMEN_BIT 0

// Zero status register fields
`define DMC_ZST_RIGHT_BIT 1
`define DMC_ZST_LEFT_BIT 0

// Identifier field width
`define DMC_ID_W 5

// Reset values
`define DMC_RST_ROLLOFF 1'b0
`define DMC_RST_ZHOLD 1'b0
`define DMC_RST_STREAM 1'b0
`define DMC_RST_BYPASS 1'b0
`define DMC_RST_MONAURAL_SELECT 1'b0
`define DMC_RST_PICK 1'b0
`define DMC_RST_RATE 2'b00
`define DMC_RST_PAT 2'b00
`define DMC_RST_PCMEN 1'b1

// Modulator rate codes
`define DMC_RATE_X64 2'b00
`define DMC_RATE_X32 2'b01
`define DMC_RATE_X128 2'b10
`define DMC_RATE_RSVD 2'b11

// Stream zero pattern codes (1x means the 96h pattern)
`define DMC_PAT_OFF 2'b00
`define DMC_PAT_EVEN 2'b01

`endif

/* File: pkg/dmc_pkg.sv */
/*
  Types shared by the mode-control register bank and its zero-flag unit.
  Assumes dmc_regs.svh is on the include path.
*/
`include "dmc_regs.svh"

package dmc_pkg;

  // One decoded control command word
  typedef struct packed {
    logic rw;
    logic [6:0] index;
    logic [7:0] data;
  } dmc_cmd_s;

  // Mode settings handed to the datapath
  typedef struct packed {
    logic rolloff;
    logic zero_hold;
    logic stream;
    logic bypass;
    logic monaural_select;
    logic pick;
    logic [1:0] rate;
  } dmc_mode_s;

  // One flag per channel
  typedef struct packed {
    logic right;
    logic left;
  } dmc_pair_s;

endpackage

/* File: rtl/dmc_zero_flags.sv */
/*
  Zero-flag gating for both channels: picks the detector that the current
  input mode uses and applies the enables. Raw detections arrive from the
  datapath synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Pattern codes
`include "dmc_regs.svh"

module dmc_zero_flags
  import dmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic stream_mode,
  input wire logic pcm_enable,
  input wire logic [1:0] pattern_sel,
  input wire dmc_pkg::dmc_pair_s pcm_zero,
  input wire dmc_pkg::dmc_pair_s even_zero,
  input wire dmc_pkg::dmc_pair_s pat96_zero,
  output dmc_pkg::dmc_pair_s flags
);

  logic [1:0] pcm_v;
  logic [1:0] even_v;
  logic [1:0] p96_v;
  logic [1:0] flag_q;

  assign pcm_v = pcm_zero;
  assign even_v = even_zero;
  assign p96_v = pat96_zero;
  assign flags = flag_q;

  //////////////////////////////////////////////////////////////////////////
  // One registered flag per channel; pins and status read the same flop
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          flag_q[ch] <= 1'b0;
        end else if (stream_mode) begin
          // Stream mode ignores the PCM enable
          if (pattern_sel == `DMC_PAT_OFF) begin
            flag_q[ch] <= 1'b0;
          end else if (pattern_sel == `DMC_PAT_EVEN) begin
            flag_q[ch] <= even_v[ch];
          end else begin
            flag_q[ch] <= p96_v[ch];
          end
        end else begin
          flag_q[ch] <= pcm_enable & pcm_v[ch];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: test/dmc_regs_sva.sv */
/* Port checker of the mode-control register bank, bound below.
   Assumes one clock domain and the dmc_pkg types. */
`timescale 1ns/1ps
`default_nettype none
module dmc_regs_sva
  import dmc_pkg::*;
#(
  parameter logic [4:0] DEVICE_ID = 5'h00 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_word,
  input wire dmc_pkg::dmc_pair_s pcm_zero,
  input wire dmc_pkg::dmc_mode_s mode,
  input wire logic [1:0] oversample_select,
  input wire logic [1:0] stream_bitclk_select,
  input wire logic monaural_select_right_pick,
  input wire logic hold_bipolar_zero,
  input wire logic soft_reset_pulse,
  input wire logic zero_pin_left,
  input wire logic [4:0] device_identifier_field
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Decoded command fields, plain nets so $past sees whole signals
  wire logic rd = cmd_valid && cmd_word[15];
  wire logic wr = cmd_valid && !cmd_word[15];
  wire logic [6:0] ix = cmd_word[14:8];
  wire logic [5:0] cm = cmd_word[5:0];
  wire logic [1:0] cf = cmd_word[1:0];
  wire logic hz = mode.zero_hold && !mode.stream && (&pcm_zero);
  wire logic sreset_wr = wr && ix == 7'h14 && cmd_word[6];
  // A lone soft reset write, then one pulse and cleared fields
  sequence s_sreset_once;
    sreset_wr ##1 !sreset_wr;
  endsequence
  sequence s_one_pulse;
    soft_reset_pulse ##1 (!soft_reset_pulse && mode == '0);
  endsequence
  property p_sreset;
    s_sreset_once |-> s_one_pulse;
  endproperty
  a_sreset: assert property (p_sreset)
    else $error("soft reset pulse wrong");
  property p_rd;
    rd |=> rsp_valid && rsp_word[15] && rsp_word[14:8] == $past(ix);
  endproperty
  a_rd: assert property (p_rd)
    else $error("read answer wrong");
  property p_wr;
    wr |=> !rsp_valid;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write gave an answer");
  // Guarded against the clearing edge of a soft reset
  property p_mode;
    wr && ix == 7'h14 && !cmd_word[6] && !soft_reset_pulse
      |=> mode[5:0] == $past(cm);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode fields not written");
  property p_filt;
    wr && ix == 7'h13 && !soft_reset_pulse |=> mode[7:6] == $past(cf);
  endproperty
  a_filt: assert property (p_filt)
    else $error("roll-off or hold enable not written");
  property p_sel;
    oversample_select == (mode.stream ? 2'b00 : mode.rate) &&
      stream_bitclk_select == (mode.stream ? mode.rate : 2'b00);
  endproperty
  a_sel: assert property (p_sel)
    else $error("rate routing wrong");
  property p_pick;
    monaural_select_right_pick == (mode.monaural_select && mode.pick);
  endproperty
  a_pick: assert property (p_pick)
    else $error("channel pick outside monaural_select");
  property p_hold;
    !$past(soft_reset_pulse) |-> hold_bipolar_zero == $past(hz);
  endproperty
  a_hold: assert property (p_hold)
    else $error("bipolar zero hold wrong");
  property p_pin;
    !mode.stream && !pcm_zero.left |=> !zero_pin_left;
  endproperty
  a_pin: assert property (p_pin)
    else $error("left zero pin without detection");
  property p_id;
    rd && ix == 7'h17 |=> rsp_word[7:0] == {3'h0, DEVICE_ID} &&
      device_identifier_field == DEVICE_ID;
  endproperty
  a_id: assert property (p_id)
    else $error("identifier wrong");
endmodule
bind dmc_mode_regs dmc_regs_sva #(.DEVICE_ID(DEVICE_ID)) u_sva (
  .sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
  .cmd_word(cmd_word), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
  .pcm_zero(pcm_zero), .mode(mode),
  .oversample_select(oversample_select),
  .stream_bitclk_select(stream_bitclk_select),
  .monaural_select_right_pick(monaural_select_right_pick),
  .hold_bipolar_zero(hold_bipolar_zero),
  .soft_reset_pulse(soft_reset_pulse), .zero_pin_left(zero_pin_left),
  .device_identifier_field(device_identifier_field));
`default_nettype wire

/* File: test/dmc_host_model.sv */
/* Host controller on the control port, one word per access.
   The bench calls its access task; words are parallel. */
`timescale 1ns/1ps
`default_nettype none
module dmc_host_model (
  input wire logic sys_clk,
  output logic cmd_valid,
  output logic [15:0] cmd_word
);
  // Idle port at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
  end
  task automatic access(input logic rw, input logic [6:0] ix,
                        input logic [7:0] d);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_word <= {rw, ix, d};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_word <= ~{rw, ix, d}; // Stale word inverted, never reused
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
/* Self-checking bench of dmc_mode_regs; commands go through
   dmc_host_model, the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dmc_pkg::*;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, g); fails++; end end
  localparam logic [4:0] ID = 5'h0b; // Arbitrary value
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid, rsp_valid, monaural_select_right_pick, hold_bipolar_zero;
  logic soft_reset_pulse, zero_pin_left, zero_pin_right;
  logic [15:0] cmd_word, rsp_word, w;
  logic [1:0] oversample_select, stream_bitclk_select;
  logic [4:0] device_identifier_field;
  logic [7:0] r;
  logic [7:0] rst_tab [5] = '{8'h00, 8'h00, 8'h01, 8'h00, {3'h0, ID}};
  dmc_pair_s pcm_zero, even_zero, pat96_zero;
  dmc_mode_s mode;
  int fails = 0;
  int compares = 0;
  int seed = 56888;
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  dmc_host_model HOST (
    .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
  dmc_mode_regs #(.DEVICE_ID(ID)) DUT (
    .sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
    .pcm_zero(pcm_zero), .even_zero(even_zero), .pat96_zero(pat96_zero),
    .mode(mode), .oversample_select(oversample_select),
    .stream_bitclk_select(stream_bitclk_select),
    .monaural_select_right_pick(monaural_select_right_pick),
    .hold_bipolar_zero(hold_bipolar_zero),
    .soft_reset_pulse(soft_reset_pulse), .zero_pin_left(zero_pin_left),
    .zero_pin_right(zero_pin_right),
    .device_identifier_field(device_identifier_field));
  // Expected pins: PCM path gated by its enable, stream path by pattern
  function automatic logic [1:0] exp_pins(logic st, logic pz,
      logic [1:0] pat, dmc_pair_s p, dmc_pair_s e, dmc_pair_s q);
    if (!st)
      return pz ? p : 2'b00;
    return pat == 2'b00 ? 2'b00 : (pat == 2'b01 ? e : q);
  endfunction
  // Verdict and end of run
  task automatic conclude();
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Write; mode outputs are settled when this returns, hold and zero pins a cycle later
  task automatic wr(input logic [6:0] ix, input logic [7:0] d);
    HOST.access(1'b0, ix, d);
    #1;
  endtask
  // Read into w; a missing answer ends the run
  task automatic rd(input logic [6:0] ix);
    int n;
    HOST.access(1'b1, ix, 8'h00);
    #1;
    for (n = 0; n < 4 && rsp_valid !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 4) begin
      fails++;
      conclude();
    end
    w = rsp_word;
  endtask
  // Main sequence
  initial begin
    pcm_zero = 2'b00;
    even_zero = 2'b00;
    pat96_zero = 2'b00;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    // Header and reset value of every register
    for (int i = 0; i < 5; i++) begin
      rd(7'h13 + 7'(i));
      `CHK("hdr", ({1'b1, 7'h13 + 7'(i)}), w[15:8])
      `CHK("rst", rst_tab[i], w[7:0])
    end
    // Mode fields: every rate code in both modes, then random
    for (int i = 0; i < 24; i++) begin
      r = 8'($random(seed)) & 8'h3f;
      if (i < 8)
        r = {2'b00, i[2], r[4:2], i[1:0]};
      wr(7'h14, r);
      `CHK("mode", r[5:0], mode[5:0])
      rd(7'h14);
      `CHK("rb14", r[6:0], w[6:0])
    end
    // Zero flags and hold over mode, enables and patterns
    for (int i = 0; i < 32; i++) begin
      wr(7'h13, {6'h00, i[0], i[4]});
      wr(7'h15, {5'h00, i[1:0], i[2]});
      wr(7'h14, {2'b00, i[3], 5'h00});
      @(posedge sys_clk);
      pcm_zero <= 2'($random(seed));
      even_zero <= 2'($random(seed));
      pat96_zero <= 2'($random(seed));
      repeat (2) @(posedge sys_clk);
      #1;
      r[1:0] = exp_pins(i[3], i[2], 2'(i), pcm_zero, even_zero, pat96_zero);
      `CHK("pins", r[1:0], ({zero_pin_right, zero_pin_left}))
      r[2] = i[4] && !i[3] && (&pcm_zero);
      `CHK("hold", r[2], hold_bipolar_zero)
      rd(7'h16);
      `CHK("stat", ({1'b1, r[1:0]}), ({w[15], w[1:0]}))
    end
    // Writes to read-only and unmapped places are dropped
    wr(7'h16, 8'hff);
    wr(7'h17, 8'hff);
    wr(7'h7f, 8'hff);
    rd(7'h17);
    `CHK("id", ({1'b1, 7'h17, 3'h0, ID}), w)
    rd(7'h7f);
    `CHK("unmap", 16'hff00, w)
    // Soft reset: one pulse, then reset values again
    wr(7'h14, 8'h7f);
    `CHK("sreset1", 1'b1, soft_reset_pulse)
    @(posedge sys_clk);
    #1;
    `CHK("sreset0", 1'b0, soft_reset_pulse)
    `CHK("mode0", 8'h00, mode)
    rd(7'h15);
    `CHK("zen", 8'h01, w[7:0])
    conclude();
  end
endmodule
`default_nettype wire
